/* verilog/eeprom_write_slave.sv */
// two-wire bus slave front end of a paged serial eeprom, write path only
// assumes scl_clk is the bus serial clock wired also into bus_in.scl, open-drain sda resolved outside
//
// Functional notes
// - array holds 4096 or 8192 bytes as pages of 32 bytes.
// - protect input high blocks whole array or top quarter, per variant.
// - start is sda falling with scl high; nothing answered before a start.
// - stop is sda rising with scl high; every operation ends with stop.
// - sda changes only with scl low; one bit per scl pulse.
// - each received byte is acknowledged by pulling sda low on clock nine.
// - slave byte matches only with type 1010 and the three strap levels.
// - unconnected strap inputs read as zero, eight devices per bus.
// - last slave bit one requests read, zero requests write.
// - byte write: slave byte, two address bytes, data byte, stop starts programming.
// - during internal programming all master requests are ignored.
// - page write accepts up to 31 further bytes, each acknowledged.
// - only low five address bits increment, wrapping within the page.
// - more than 32 bytes overwrite earlier bytes of the same page.
// - after stop all buffered page bytes commit in one self-timed cycle.
// - write cycle lasts about 5 ms and clears itself.
// - a start resets any interrupted transfer.
// - standby at power-up until a pin toggles, after idle stop, after writes.
// - slave write byte is not acknowledged while programming is busy.
`default_nettype none

module eeprom_write_slave
    import eeprom_pkg::*;
#(
    parameter int MEM_BYTES = MEM_BYTES_DEF,
    parameter bit PROTECT_ALL = 1'b0,
    parameter int WRITE_CYCLES = WRITE_CYCLES_DEF
) (
    // core clock and reset
    input wire logic mclk,
    input wire logic srst,
    // serial clock domain
    input wire logic scl_clk,
    // bus pins
    input wire eeprom_pkg::bus_pins_type bus_in,
    output eeprom_pkg::sda_drive_type sda_drive,
    // straps and protect
    input wire logic addr_strap_bit0,
    input wire logic addr_strap_bit1,
    input wire logic addr_strap_bit2,
    input wire logic write_protect,
    // array inspection
    input wire logic [eeprom_pkg::WADDR_W-1:0] peek_addr,
    output logic [7:0] peek_data,
    // status
    output logic busy,
    output logic standby
);

    import eeprom_pkg::*;

    localparam int ADDR_W = $clog2(MEM_BYTES);
    localparam int PAGE_W = ADDR_W - OFS_W;
    localparam int WCNT_W = $clog2(WRITE_CYCLES + 1);
    localparam logic [ADDR_W-1:0] PROT_BASE = ADDR_W'(MEM_BYTES / PROT_DEN * PROT_NUM);
    localparam logic [WCNT_W-1:0] WCNT_LOAD = WCNT_W'(WRITE_CYCLES - 1);
    localparam logic [OFS_W:0] COMMIT_END = (OFS_W + 1)'(PAGE_BYTES);

    if (MEM_BYTES != MEM_BYTES_SMALL && MEM_BYTES != MEM_BYTES_LARGE) begin : g_bad_size
        $error("MEM_BYTES must be 4096 or 8192");
    end
    if (WRITE_CYCLES <= PAGE_BYTES) begin : g_bad_time
        $error("WRITE_CYCLES must exceed the page size");
    end

    ////////////////////////////////////////////////////////////////////////////
    // serial clock domain: sample sda on each rising scl edge

    logic link_bit_r, link_tog_r;

    // only these two flops live on scl; reset is asynchronous since scl may be still
    always_ff @(posedge scl_clk or posedge srst) begin
        if (srst) begin
            link_bit_r <= 1'b0;
            link_tog_r <= 1'b0;
        end else begin
            link_bit_r <= bus_in.sda;
            link_tog_r <= ~link_tog_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // crossings into mclk

    bus_pins_type pins_q;
    bus_pins_type pins_prev_r;
    logic tog_q;
    logic tog_seen_r;
    logic [3:0] straps_q;

    pin_filter #(
        .WIDTH(2),
        .RESET_VAL(BUS_IDLE)
    ) u_bus_filter (
        .mclk(mclk),
        .srst(srst),
        .async_in(bus_in),
        .level_q(pins_q)
    );

    // the bit toggle is an event; link_bit_r is held for a whole scl period, so it
    // is read directly once the toggle has crossed (scl high+low must exceed ~5 mclk)
    pin_filter #(
        .WIDTH(1),
        .RESET_VAL(1'b0)
    ) u_tog_filter (
        .mclk(mclk),
        .srst(srst),
        .async_in(link_tog_r),
        .level_q(tog_q)
    );

    pin_filter #(
        .WIDTH(4),
        .RESET_VAL(STRAP_RST)
    ) u_strap_filter (
        .mclk(mclk),
        .srst(srst),
        .async_in({addr_strap_bit2, addr_strap_bit1, addr_strap_bit0, write_protect}),
        .level_q(straps_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // bus event decode

    logic [2:0] strap_lvl;
    logic wp_lvl, start_evt, stop_evt, scl_fall, pin_toggle, bit_evt;

    // floating straps are pulled low at the pad, so a missing strap compares as zero
    assign strap_lvl = straps_q[3:1];
    assign wp_lvl = straps_q[0];
    assign start_evt = pins_prev_r.scl & pins_q.scl & pins_prev_r.sda & ~pins_q.sda;
    assign stop_evt = pins_prev_r.scl & pins_q.scl & ~pins_prev_r.sda & pins_q.sda;
    assign scl_fall = pins_prev_r.scl & ~pins_q.scl;
    assign pin_toggle = (pins_prev_r != pins_q);
    assign bit_evt = tog_q ^ tog_seen_r;

    ////////////////////////////////////////////////////////////////////////////
    // transfer state

    xfer_state_type state_r;
    xfer_state_type state_nxt;
    logic [3:0] bitcnt_r;
    logic [3:0] bitcnt_nxt;
    logic [7:0] shift_r;
    logic ack_oe_r, ack_oe_nxt;
    logic [WADDR_W-1:0] waddr_r;
    logic pend_r, busy_r;
    logic [WCNT_W-1:0] wcnt_r;
    logic [OFS_W:0] commit_r;
    logic standby_r;
    logic [7:0] peek_data_r;
    logic [PAGE_BYTES-1:0] mask_r;
    logic [7:0] page_buf [PAGE_BYTES];
    logic [7:0] mem [MEM_BYTES];

    logic active, byte_done, ack_end, dev_match, take_hi, take_lo, take_data;
    logic write_go, idle_stop, write_done, committing, prot_hit;
    logic [OFS_W-1:0] commit_ofs;
    logic [ADDR_W-1:0] commit_addr;
    logic [OFS_W-1:0] ofs_inc;

    assign active = (state_r == ST_DEVADDR) || (state_r == ST_ADDR_HI) ||
                    (state_r == ST_ADDR_LO) || (state_r == ST_DATA);
    assign byte_done = active & scl_fall & (bitcnt_r == BITS_PER_BYTE);
    assign ack_end = active & scl_fall & (bitcnt_r == ACK_CLOCK);

    // a read request or a busy array leaves the slave byte unanswered
    assign dev_match = (shift_r[7:4] == DEV_TYPE_CODE) && (shift_r[3:1] == strap_lvl) &&
                       (shift_r[0] == RW_WRITE) &&
                       !busy_r;

    assign take_hi = byte_done & (state_r == ST_ADDR_HI);
    assign take_lo = byte_done & (state_r == ST_ADDR_LO);
    assign take_data = byte_done & (state_r == ST_DATA);
    assign write_go = stop_evt & (state_r == ST_DATA) & pend_r;
    assign idle_stop = stop_evt & ~write_go & ~busy_r;
    assign write_done = busy_r & (wcnt_r == '0);
    assign ofs_inc = waddr_r[OFS_W-1:0] + OFS_W'(1);

    // commit walks the page buffer during the first cycles of the write time
    assign committing = busy_r & (commit_r < COMMIT_END);
    assign commit_ofs = commit_r[OFS_W-1:0];
    assign commit_addr = {waddr_r[ADDR_W-1:OFS_W], commit_ofs};
    assign prot_hit = wp_lvl & (PROTECT_ALL || (commit_addr >= PROT_BASE));

    ////////////////////////////////////////////////////////////////////////////
    // transfer sequencing

    always_comb begin
        state_nxt = state_r;
        bitcnt_nxt = bitcnt_r;
        ack_oe_nxt = ack_oe_r;
        if (start_evt) begin
            // a start abandons whatever was in flight, even mid-byte
            state_nxt = ST_DEVADDR;
            bitcnt_nxt = 4'h0;
            ack_oe_nxt = 1'b0;
        end else if (stop_evt) begin
            state_nxt = ST_IDLE;
            bitcnt_nxt = 4'h0;
            ack_oe_nxt = 1'b0;
        end else if (ack_end) begin
            bitcnt_nxt = 4'h0;
            ack_oe_nxt = 1'b0;
        end else if (byte_done) begin
            case (state_r)
                ST_DEVADDR: begin
                    if (dev_match) begin
                        state_nxt = ST_ADDR_HI;
                        ack_oe_nxt = 1'b1;
                    end else begin
                        // not for us, a read, or busy: stay quiet until the next start
                        state_nxt = ST_IGNORE;
                    end
                end
                ST_ADDR_HI: begin
                    state_nxt = ST_ADDR_LO;
                    ack_oe_nxt = 1'b1;
                end
                ST_ADDR_LO: begin
                    state_nxt = ST_DATA;
                    ack_oe_nxt = 1'b1;
                end
                ST_DATA: begin
                    // protected data is still acknowledged; the commit drops it
                    ack_oe_nxt = 1'b1;
                end
                default: begin
                    state_nxt = ST_IGNORE;
                end
            endcase
        end else if (active && bit_evt && bitcnt_r < ACK_CLOCK) begin
            bitcnt_nxt = bitcnt_r + 4'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            state_r <= ST_IDLE;
            bitcnt_r <= 4'h0;
            ack_oe_r <= 1'b0;
            pins_prev_r <= BUS_IDLE;
            tog_seen_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            bitcnt_r <= bitcnt_nxt;
            ack_oe_r <= ack_oe_nxt;
            pins_prev_r <= pins_q;
            tog_seen_r <= tog_q;
        end
    end

    // received bits shift in msb first; the ack-clock sample is not kept
    always_ff @(posedge mclk) begin
        if (srst) begin
            shift_r <= 8'h00;
        end else if (active && bit_evt && bitcnt_r < BITS_PER_BYTE) begin
            shift_r <= {shift_r[6:0], link_bit_r};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // word address and page buffer

    always_ff @(posedge mclk) begin
        if (srst) begin
            waddr_r <= '0;
        end else if (take_hi) begin
            waddr_r[WADDR_W-1:8] <= shift_r[ADDR_HI_W-1:0];
        end else if (take_lo) begin
            waddr_r[7:0] <= shift_r;
        end else if (take_data) begin
            waddr_r[OFS_W-1:0] <= ofs_inc;
        end
    end

    // a later byte to the same offset simply replaces the earlier one
    always_ff @(posedge mclk) begin
        if (take_data) begin
            page_buf[waddr_r[OFS_W-1:0]] <= shift_r;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            mask_r <= '0;
            pend_r <= 1'b0;
        end else if ((start_evt && !busy_r) || take_lo) begin
            // a polling start during the write must not drop the mask the commit reads
            mask_r <= '0;
            pend_r <= 1'b0;
        end else if (take_data) begin
            mask_r[waddr_r[OFS_W-1:0]] <= 1'b1;
            pend_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // self-timed write cycle

    always_ff @(posedge mclk) begin
        if (srst) begin
            busy_r <= 1'b0;
            wcnt_r <= '0;
            commit_r <= '0;
        end else if (write_go) begin
            busy_r <= 1'b1;
            wcnt_r <= WCNT_LOAD;
            commit_r <= '0;
        end else if (write_done) begin
            busy_r <= 1'b0;
        end else if (busy_r) begin
            wcnt_r <= wcnt_r - WCNT_W'(1);
            if (committing) begin
                commit_r <= commit_r + (OFS_W + 1)'(1);
            end
        end
    end

    // the page address is frozen while busy since no slave byte is accepted then
    always_ff @(posedge mclk) begin
        if (committing && mask_r[commit_ofs] && !prot_hit) begin
            mem[commit_addr] <= page_buf[commit_ofs];
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            peek_data_r <= 8'h00;
        end else begin
            peek_data_r <= mem[peek_addr[ADDR_W-1:0]];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // standby tracking

    // a stop is itself an sda toggle, so entering standby must win over leaving it
    always_ff @(posedge mclk) begin
        if (srst) begin
            standby_r <= 1'b1;
        end else if (idle_stop || write_done) begin
            standby_r <= 1'b1;
        end else if (pin_toggle || write_go) begin
            standby_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    // open drain: the pad only ever pulls low
    assign sda_drive = '{out: 1'b0, oe: ack_oe_r};
    assign peek_data = peek_data_r;
    assign busy = busy_r;
    assign standby = standby_r;

endmodule

`default_nettype wire

/* shared/eeprom_pkg.sv */
// constants, states and carrier types of the two-wire eeprom write slave
// assumes a 100 MHz core clock; the serial clock arrives from the bus master
`default_nettype none

package eeprom_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // array organisation
    localparam int PAGE_BYTES = 32;
    localparam int OFS_W = 5;
    localparam int WADDR_W = 13;
    localparam int ADDR_HI_W = WADDR_W - 8;
    localparam int MEM_BYTES_SMALL = 4096;
    localparam int MEM_BYTES_LARGE = 8192;
    localparam int MEM_BYTES_DEF = MEM_BYTES_LARGE;
    // protected top quarter starts at three quarters of the array
    localparam int PROT_NUM = 3;
    localparam int PROT_DEN = 4;

    ////////////////////////////////////////////////////////////////////////////
    // slave address byte
    localparam logic [3:0] DEV_TYPE_CODE = 4'hA;
    localparam logic RW_WRITE = 1'h0;
    localparam logic RW_READ = 1'h1;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] ACK_CLOCK = 4'h9;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_HZ = 100_000_000;
    localparam int WRITE_TIME_MS = 5;
    localparam int WRITE_CYCLES_DEF = WRITE_TIME_MS * (CLK_HZ / 1000);
    localparam int SYNC_STAGES = 3;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [1:0] BUS_IDLE = 2'h3;
    localparam logic [3:0] STRAP_RST = 4'h0;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DEVADDR = 3'b001,
        ST_ADDR_HI = 3'b010,
        ST_ADDR_LO = 3'b011,
        ST_DATA = 3'b100,
        ST_IGNORE = 3'b101
    } xfer_state_type;

    typedef struct packed {
        logic scl;
        logic sda;
    } bus_pins_type;

    typedef struct packed {
        logic out;
        logic oe;
    } sda_drive_type;

endpackage

`default_nettype wire

/* verilog/pin_filter.sv */
// three-stage synchroniser with agreement filter for asynchronous inputs
// assumes inputs are unrelated to mclk; output moves only when stages 2 and 3 agree
`default_nettype none

module pin_filter #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // asynchronous levels in, filtered levels out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] level_q
);

    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;
    logic [WIDTH-1:0] stage3_r;
    logic [WIDTH-1:0] level_r;
    logic [WIDTH-1:0] agree;
    logic [WIDTH-1:0] level_nxt;

    // stage1 feeds stage2 only; the filter looks at stages 2 and 3
    assign agree = ~(stage2_r ^ stage3_r);
    assign level_nxt = (agree & stage3_r) | (~agree & level_r);
    assign level_q = level_r;

    always_ff @(posedge mclk) begin
        if (srst) begin
            stage1_r <= RESET_VAL;
            stage2_r <= RESET_VAL;
            stage3_r <= RESET_VAL;
            level_r <= RESET_VAL;
        end else begin
            stage1_r <= async_in;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
            level_r <= level_nxt;
        end
    end

endmodule

`default_nettype wire

/* testbench/two_wire_master.sv */
// two-wire bus master model: drives the serial clock and pulls the data wire
// assumes the bench resolves the data wire with a pull-up and feeds it back
`default_nettype none

module two_wire_master (
    // bus lines
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    ////////////////////////////////
    // data moves only while the clock is low; lo stretches the low phase
    task automatic put_bit(input logic b, input int lo, output logic seen);
        #20 sda_low = !b;
        #(lo - 20) scl = 1'b1;
        #39 seen = sda;
        #1 scl = 1'b0;
    endtask

    // also serves as repeated start, which aborts a half-done transfer
    task automatic start_cond();
        #3;
        if (!scl) begin
            #20 sda_low = 1'b0;
            #20 scl = 1'b1;
            #100;
        end
        sda_low = 1'b1;
        #100 scl = 1'b0;
    endtask

    task automatic stop_cond();
        #20 sda_low = 1'b1;
        #20 scl = 1'b1;
        #100 sda_low = 1'b0;
        #100;
    endtask

    task automatic clock_low();
        #40 scl = 1'b0;
    endtask

    // long low phases around the ninth clock leave the slave time to answer
    task automatic send_byte(input logic [7:0] b, output logic acked);
        logic seen;
        for (int i = 7; i >= 0; i--) put_bit(b[i], 40, seen);
        put_bit(1'b1, 120, seen);
        acked = !seen;
        #80;
    endtask
endmodule

`default_nettype wire

/* testbench/write_slave_sva.sv */
// concurrent checks on the ports of the eeprom write slave
// assumes one core clock domain; bound into every slave instance
`default_nettype none

module write_slave_checker
    import eeprom_pkg::*;
#(
    parameter int WRITE_CYCLES = WRITE_CYCLES_DEF
) (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // bus pins
    input wire eeprom_pkg::bus_pins_type bus_in,
    input wire eeprom_pkg::sda_drive_type sda_drive,
    // status
    input wire logic busy,
    input wire logic standby
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);

    int busy_cnt_r;

    always_ff @(posedge mclk) begin
        if (srst || !busy) begin
            busy_cnt_r <= 0;
        end else begin
            busy_cnt_r <= busy_cnt_r + 1;
        end
    end

    ////////////////////////////////
    reset_state_a: assert property (disable iff (1'b0) srst |=> !busy && standby && !sda_drive.oe)
        else $error("status not at reset values");
    busy_length_a: assert property ($fell(busy) |-> busy_cnt_r == WRITE_CYCLES)
        else $error("write cycle length wrong");
    busy_quiet_a: assert property (busy |-> !sda_drive.oe)
        else $error("acknowledge while busy");
    write_start_a: assert property ($rose(busy) |-> bus_in.scl && bus_in.sda)
        else $error("write began on a busy bus");
    busy_awake_a: assert property (busy |-> !standby)
        else $error("standby during write");
    write_end_a: assert property ($fell(busy) |-> ##[0:1] standby)
        else $error("no standby after write");
    ack_rise_a: assert property ($rose(sda_drive.oe) |-> !bus_in.scl)
        else $error("acknowledge began with clock high");
    ack_fall_a: assert property ($fell(sda_drive.oe) |-> !bus_in.scl)
        else $error("acknowledge ended with clock high");
    ack_width_a: assert property ($rose(sda_drive.oe) |=> sda_drive.oe [*8])
        else $error("acknowledge too short");
    open_drain_a: assert property (!sda_drive.out)
        else $error("data driven high");
endmodule

bind eeprom_write_slave write_slave_checker #(.WRITE_CYCLES(WRITE_CYCLES)) write_slave_checker_inst (
    .mclk(mclk), .srst(srst), .bus_in(bus_in), .sda_drive(sda_drive), .busy(busy), .standby(standby));

`default_nettype wire

/* testbench/tb_eeprom_write_slave.sv */
// self-checking bench for the eeprom write slave
// assumes the master model owns the serial clock; the data wire has a pull-up
`default_nettype none

module tb_eeprom_write_slave;
    import eeprom_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int WCYC = 200;
    localparam int LIMIT = 60000;

    typedef struct packed {
        logic [2:0] strap;
        logic [7:0] slave;
        logic [15:0] addr;
        logic [7:0] data;
        logic wp;
        logic ack;
        logic [7:0] exp_data;
    } row_type;

    logic mclk;
    logic srst = 1'b1;
    logic m_scl;
    logic m_low;
    logic sda_w;
    logic [2:0] strap = 3'h0;
    logic write_protect = 1'b0;
    logic [WADDR_W-1:0] peek_addr = '0;
    logic [7:0] peek_data;
    logic busy;
    logic standby;
    logic acked;
    bus_pins_type bus_in;
    sda_drive_type sda_drive;
    int miscompares = 0;
    int total_checks = 0;
    row_type rows [8];
    logic [7:0] page_exp [32];

    assign sda_w = !(m_low || sda_drive.oe);
    assign bus_in = {m_scl, sda_w};

    eeprom_write_slave #(.WRITE_CYCLES(WCYC)) eeprom_write_slave_inst (
        .mclk(mclk), .srst(srst), .scl_clk(m_scl), .bus_in(bus_in), .sda_drive(sda_drive),
        .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]),
        .write_protect(write_protect), .peek_addr(peek_addr), .peek_data(peek_data),
        .busy(busy), .standby(standby));

    two_wire_master two_wire_master_inst (.scl(m_scl), .sda_low(m_low), .sda(sda_w));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = !mclk;
    end

    ////////////////////////////////
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic wait_write();
        repeat (100) if (busy !== 1'b1) @(negedge mclk);
        check("write_start", 16'({busy, standby}), 16'h0002);
        repeat (WCYC + 50) if (busy !== 1'b0) @(negedge mclk);
        check("write_end", 16'({busy, standby}), 16'h0001);
    endtask

    task automatic peek(input logic [12:0] a, input logic [7:0] exp);
        @(negedge mclk);
        peek_addr = a;
        repeat (2) @(negedge mclk);
        check("peek_data", 16'(peek_data), 16'(exp));
    endtask

    // full write: slave byte, two address bytes, one data byte, stop; only the slave byte and stop when no ack is expected
    task automatic xfer(input logic [7:0] slave, input logic [15:0] addr, input logic [7:0] data, input logic ack);
        logic [23:0] w;
        w = {addr, data};
        two_wire_master_inst.start_cond();
        two_wire_master_inst.send_byte(slave, acked);
        check("slave_ack", 16'(acked), 16'(ack));
        for (int i = 2; i >= 0 && ack; i--) begin
            two_wire_master_inst.send_byte(w[i*8 +: 8], acked);
            check("byte_ack", 16'(acked), 16'h0001);
        end
        two_wire_master_inst.stop_cond();
    endtask

    initial begin
        repeat (LIMIT) @(posedge mclk);
        miscompares++;
        tally_and_finish();
    end

    initial begin
        rows[0] = '{3'h0, 8'hA0, 16'h0010, 8'h5A, 1'b0, 1'b1, 8'h5A};
        rows[1] = '{3'h7, 8'hAE, 16'h0123, 8'h3C, 1'b1, 1'b1, 8'h3C};
        rows[2] = '{3'h7, 8'hA0, 16'h0123, 8'h99, 1'b0, 1'b0, 8'h00};
        rows[3] = '{3'h0, 8'hA1, 16'h0010, 8'h99, 1'b0, 1'b0, 8'h00};
        rows[4] = '{3'h0, 8'hB0, 16'h0010, 8'h99, 1'b0, 1'b0, 8'h00};
        rows[5] = '{3'h0, 8'hA0, 16'h1800, 8'h11, 1'b0, 1'b1, 8'h11};
        rows[6] = '{3'h0, 8'hA0, 16'h1800, 8'h77, 1'b1, 1'b1, 8'h11};
        rows[7] = '{3'h0, 8'hA0, 16'h17FF, 8'h22, 1'b1, 1'b1, 8'h22};
        repeat (10) @(negedge mclk);
        check("reset_status", 16'({busy, standby, sda_drive.oe}), 16'h0002);
        srst = 1'b0;
        repeat (5) @(negedge mclk);
        // a byte with no start before it must be ignored
        two_wire_master_inst.clock_low();
        two_wire_master_inst.send_byte(8'hA0, acked);
        check("no_start_ack", 16'(acked), 16'h0000);
        check("woken", 16'(standby), 16'h0000);
        two_wire_master_inst.stop_cond();
        check("idle_stop", 16'({busy, standby}), 16'h0001);
        foreach (rows[i]) begin
            @(negedge mclk);
            strap = rows[i].strap;
            write_protect = rows[i].wp;
            xfer(rows[i].slave, rows[i].addr, rows[i].data, rows[i].ack);
            if (rows[i].ack) begin
                wait_write();
                peek(rows[i].addr[12:0], rows[i].exp_data);
            end else begin
                check("refused", 16'({busy, standby}), 16'h0001);
            end
        end
        write_protect = 1'b0;
        // a repeated start in mid-address restarts the transfer
        two_wire_master_inst.start_cond();
        two_wire_master_inst.send_byte(8'hA0, acked);
        two_wire_master_inst.send_byte(8'h02, acked);
        xfer(8'hA0, 16'h0200, 8'hC3, 1'b1);
        wait_write();
        peek(13'h0200, 8'hC3);
        // page write of 34 bytes from offset 5 wraps and overwrites
        two_wire_master_inst.start_cond();
        two_wire_master_inst.send_byte(8'hA0, acked);
        two_wire_master_inst.send_byte(8'h00, acked);
        two_wire_master_inst.send_byte(8'h45, acked);
        for (int i = 0; i < 34; i++) begin
            two_wire_master_inst.send_byte(8'h80 + 8'(i), acked);
            check("page_ack", 16'(acked), 16'h0001);
            page_exp[(5 + i) % 32] = 8'h80 + 8'(i);
        end
        two_wire_master_inst.stop_cond();
        repeat (10) @(negedge mclk);
        xfer(8'hA0, 16'h0000, 8'h00, 1'b0);
        wait_write();
        for (int i = 0; i < 32; i++) peek(13'h0040 + 13'(i), page_exp[i]);
        tally_and_finish();
    end
endmodule

`default_nettype wire
